// ==== hdl/iscb_pkg.sv ====
/*
 package for the instrument status condition block: register bit positions,
 masks of used bits, transition filter resets and status byte bit positions.
 assumes nothing of its surroundings.
*/
package iscb_pkg;
    localparam int COND_W = 16;
    // measurement quality group
    localparam int QUAL_DATA_BIT = 3;
    localparam int QUAL_CAL_BIT = 8;
    localparam int QUAL_SELFTEST_BIT = 9;
    localparam logic [15:0] QUAL_USED = 16'h0308;
    // measurement process group
    localparam int PROC_CAL_BIT = 0;
    localparam int PROC_MEAS_BIT = 4;
    localparam int PROC_TRIG_BIT = 5;
    localparam int PROC_NVM_BIT = 10;
    localparam int PROC_LLIM_BIT = 11;
    localparam int PROC_ULIM_BIT = 12;
    localparam logic [15:0] PROC_USED = 16'h1c31;
    // device fault group
    localparam int FAULT_HW_BIT = 3;
    localparam logic [15:0] FAULT_USED = 16'h0008;
    // reset values
    localparam logic [15:0] ENABLE_RST = 16'h0000;
    localparam logic [15:0] PTR_RST = 16'hffff;
    localparam logic [15:0] NTR_RST = 16'h0000;
    localparam logic [7:0] ESE_RST = 8'h00;
    // standard event and status byte bit positions
    localparam int ESR_OPC_BIT = 0;
    localparam int STB_FAULT_BIT = 1;
    localparam int STB_QUAL_BIT = 3;
    localparam int STB_MAV_BIT = 4;
    localparam int STB_ESB_BIT = 5;
    localparam int STB_PROC_BIT = 7;
    // value queued by the completion query
    localparam logic [7:0] OPC_REPLY = 8'h01;
    // group select codes on the status command port
    localparam logic [1:0] GRP_QUAL = 2'h0;
    localparam logic [1:0] GRP_PROC = 2'h1;
    localparam logic [1:0] GRP_FAULT = 2'h2;
endpackage : iscb_pkg

// ==== hdl/iscb_event_group.sv ====
/*
 one 16-bit status group: transition filters, sticky event latch, enable mask
 and summary. the condition word comes in already masked to its used bits.
 assumes the caller strobes read and clear for one cycle each.
*/
`timescale 1ns/10ps
module iscb_event_group #(
    parameter int W = 16
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [W-1:0] cond,
    input wire logic [W-1:0] ptr,
    input wire logic [W-1:0] ntr,
    input wire logic [W-1:0] enable,
    input wire logic evt_read,
    input wire logic evt_clear,
    output logic [W-1:0] event_ff,
    output logic summary
);
    logic [W-1:0] cond_ff;
    logic [W-1:0] rise;
    logic [W-1:0] fall;

    always_ff @(posedge clk) begin
        if (rst) begin
            cond_ff <= '0;
        end else begin
            cond_ff <= cond;
        end
    end

    assign rise = cond & ~cond_ff & ptr;
    assign fall = ~cond & cond_ff & ntr;

    // a change in the read cycle survives: set beats clear
    always_ff @(posedge clk) begin
        if (rst) begin
            event_ff <= '0;
        end else if (evt_read || evt_clear) begin
            event_ff <= rise | fall;
        end else begin
            event_ff <= event_ff | rise | fall;
        end
    end

    assign summary = |(event_ff & enable);
endmodule : iscb_event_group

// ==== hdl/iscb_opc_tracker.sv ====
/*
 operation complete tracker: waits for the pending command count to reach
 zero, then either queues the reply of the query or sets the standard event
 bit. assumes pend_busy covers every command accepted before the request.
*/
`timescale 1ns/10ps
module iscb_opc_tracker (
    input wire logic clk,
    input wire logic rst,
    input wire logic pend_busy,
    input wire logic opc_query,
    input wire logic opc_cmd,
    input wire logic abort,
    output logic reply_push,
    output logic esr_set
);
    logic query_wait_ff;
    logic cmd_wait_ff;

    always_ff @(posedge clk) begin
        if (rst || abort) begin
            query_wait_ff <= 1'b0;
        end else if (opc_query || query_wait_ff) begin
            query_wait_ff <= pend_busy;
        end
    end

    always_ff @(posedge clk) begin
        if (rst || abort) begin
            cmd_wait_ff <= 1'b0;
        end else if (opc_cmd || cmd_wait_ff) begin
            cmd_wait_ff <= pend_busy;
        end
    end

    // completion is only signalled once nothing is pending
    assign reply_push = (opc_query || query_wait_ff) && !pend_busy && !rst && !abort;
    assign esr_set = (opc_cmd || cmd_wait_ff) && !pend_busy && !rst && !abort;
endmodule : iscb_opc_tracker

// ==== hdl/iscb_status_core.sv ====
/*
 status condition core of the measurement instrument: three condition groups,
 their event registers and masks, the standard event register, completion
 tracking and the status byte. assumes the command decoder outside presents
 each status command as a one-cycle strobe with its data, and the measurement
 engine reports its events as one-cycle strobes or levels, all on REF_CLK.
*/
`timescale 1ns/10ps
// Functional notes
// - quality bit 3 sets on stale data, overload or zero error; clean measurement clears
// - quality bit 8 sets on zero/cal command error; clears on error-free success
// - quality bit 9 follows power-on self-test: set on fail, clear on pass
// - quality summary reports only bits enabled by the quality enable mask
// - process bit 0 high from start to end of zeroing or calibration
// - process bit 4 high while a measurement is being taken
// - process bit 5 sets entering wait-for-trigger, clears entering idle
// - process bit 10 high only while reading non-volatile memory
// - after each measurement, bit 11 set on lower limit fail, else cleared
// - after each measurement, bit 12 set on upper limit fail, else cleared
// - fault bit 3 set while memory or hardware has failed, otherwise clear
// - completion query queues value 1 once all pending commands finish
// - completion command sets standard event bit 0 once operations finish
// - status byte query returns summaries without clearing anything
// - bit 15 of every 16-bit group always reads zero
// - filtered condition changes latch into event bits; reading clears them
module iscb_status_core #(
    parameter int W = iscb_pkg::COND_W
) (
    input wire logic REF_CLK,
    input wire logic SYS_RST,
    // measurement engine events
    input wire logic MEAS_DONE,
    input wire logic MEAS_DATA_ERR,
    input wire logic MEAS_ACTIVE,
    input wire logic LOWER_LIMIT_EN,
    input wire logic LOWER_LIMIT_FAIL,
    input wire logic UPPER_LIMIT_EN,
    input wire logic UPPER_LIMIT_FAIL,
    input wire logic CAL_START,
    input wire logic CAL_END,
    input wire logic CAL_ERR,
    input wire logic SELFTEST_DONE,
    input wire logic SELFTEST_FAIL,
    input wire logic TRIG_WAIT_ENTER,
    input wire logic TRIG_IDLE_ENTER,
    input wire logic NVM_READING,
    input wire logic HW_FAILED,
    input wire logic PEND_BUSY,
    // status command strobes
    input wire logic [1:0] GRP_SEL,
    input wire logic [15:0] WR_DATA,
    input wire logic ENABLE_WR,
    input wire logic PTR_WR,
    input wire logic NTR_WR,
    input wire logic COND_RD,
    input wire logic EVENT_RD,
    input wire logic ESE_WR,
    input wire logic ESR_RD,
    input wire logic STB_RD,
    input wire logic CLS,
    input wire logic DEV_CLEAR,
    input wire logic OPC_QUERY,
    input wire logic OPC_CMD,
    input wire logic OUTQ_NOT_EMPTY,
    // answers
    output logic [15:0] RD_DATA,
    output logic RD_VALID,
    output logic OUTQ_PUSH,
    output logic [7:0] OUTQ_DATA,
    output logic [15:0] QUAL_COND,
    output logic [15:0] PROC_COND,
    output logic [15:0] FAULT_COND
);
    logic [W-1:0] qual_ff;
    logic [W-1:0] proc_ff;
    logic fault_ff;
    logic [W-1:0] qual_en_ff;
    logic [W-1:0] proc_en_ff;
    logic [W-1:0] fault_en_ff;
    logic [W-1:0] qual_ptr_ff;
    logic [W-1:0] proc_ptr_ff;
    logic [W-1:0] fault_ptr_ff;
    logic [W-1:0] qual_ntr_ff;
    logic [W-1:0] proc_ntr_ff;
    logic [W-1:0] fault_ntr_ff;
    logic [W-1:0] qual_evt;
    logic [W-1:0] proc_evt;
    logic [W-1:0] fault_evt;
    logic qual_sum;
    logic proc_sum;
    logic fault_sum;
    logic [7:0] ese_ff;
    logic [7:0] esr_ff;
    logic [W-1:0] qual_view;
    logic [W-1:0] proc_view;
    logic [W-1:0] fault_view;
    logic [7:0] stb;
    logic opc_push;
    logic opc_set;
    logic [W-1:0] rd_mux;

    function automatic logic sel_wr(input logic strobe, input logic [1:0] sel,
                                    input logic [1:0] grp);
        sel_wr = strobe && (sel == grp);
    endfunction : sel_wr

    // quality condition bits
    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            qual_ff <= '0;
        end else begin
            if (MEAS_DONE) begin
                qual_ff[iscb_pkg::QUAL_DATA_BIT] <= MEAS_DATA_ERR;
            end
            if (CAL_END) begin
                qual_ff[iscb_pkg::QUAL_CAL_BIT] <= CAL_ERR;
            end
            if (SELFTEST_DONE) begin
                qual_ff[iscb_pkg::QUAL_SELFTEST_BIT] <= SELFTEST_FAIL;
            end
        end
    end

    // process condition bits driven by events
    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            proc_ff <= '0;
        end else begin
            if (CAL_START) begin
                proc_ff[iscb_pkg::PROC_CAL_BIT] <= 1'b1;
            end else if (CAL_END) begin
                proc_ff[iscb_pkg::PROC_CAL_BIT] <= 1'b0;
            end
            // device clear returns the trigger system to idle
            if (TRIG_IDLE_ENTER || DEV_CLEAR) begin
                proc_ff[iscb_pkg::PROC_TRIG_BIT] <= 1'b0;
            end else if (TRIG_WAIT_ENTER) begin
                proc_ff[iscb_pkg::PROC_TRIG_BIT] <= 1'b1;
            end
            if (MEAS_DONE) begin
                proc_ff[iscb_pkg::PROC_LLIM_BIT] <= LOWER_LIMIT_EN && LOWER_LIMIT_FAIL;
                proc_ff[iscb_pkg::PROC_ULIM_BIT] <= UPPER_LIMIT_EN && UPPER_LIMIT_FAIL;
            end
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            fault_ff <= 1'b0;
        end else begin
            fault_ff <= HW_FAILED;
        end
    end

    // level-following bits are merged in here; unused bits and bit 15 are forced low
    always_comb begin
        qual_view = qual_ff & iscb_pkg::QUAL_USED;
        proc_view = proc_ff;
        proc_view[iscb_pkg::PROC_MEAS_BIT] = MEAS_ACTIVE && !MEAS_DONE;
        proc_view[iscb_pkg::PROC_NVM_BIT] = NVM_READING;
        proc_view = proc_view & iscb_pkg::PROC_USED;
        fault_view = '0;
        fault_view[iscb_pkg::FAULT_HW_BIT] = fault_ff;
        fault_view = fault_view & iscb_pkg::FAULT_USED;
    end

    // masks and transition filters, written by status commands
    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            qual_en_ff <= iscb_pkg::ENABLE_RST;
            proc_en_ff <= iscb_pkg::ENABLE_RST;
            fault_en_ff <= iscb_pkg::ENABLE_RST;
        end else begin
            if (sel_wr(ENABLE_WR, GRP_SEL, iscb_pkg::GRP_QUAL)) begin
                qual_en_ff <= WR_DATA & iscb_pkg::QUAL_USED;
            end
            if (sel_wr(ENABLE_WR, GRP_SEL, iscb_pkg::GRP_PROC)) begin
                proc_en_ff <= WR_DATA & iscb_pkg::PROC_USED;
            end
            if (sel_wr(ENABLE_WR, GRP_SEL, iscb_pkg::GRP_FAULT)) begin
                fault_en_ff <= WR_DATA & iscb_pkg::FAULT_USED;
            end
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            qual_ptr_ff <= iscb_pkg::PTR_RST;
            proc_ptr_ff <= iscb_pkg::PTR_RST;
            fault_ptr_ff <= iscb_pkg::PTR_RST;
            qual_ntr_ff <= iscb_pkg::NTR_RST;
            proc_ntr_ff <= iscb_pkg::NTR_RST;
            fault_ntr_ff <= iscb_pkg::NTR_RST;
        end else begin
            if (sel_wr(PTR_WR, GRP_SEL, iscb_pkg::GRP_QUAL)) begin
                qual_ptr_ff <= WR_DATA;
            end
            if (sel_wr(PTR_WR, GRP_SEL, iscb_pkg::GRP_PROC)) begin
                proc_ptr_ff <= WR_DATA;
            end
            if (sel_wr(PTR_WR, GRP_SEL, iscb_pkg::GRP_FAULT)) begin
                fault_ptr_ff <= WR_DATA;
            end
            if (sel_wr(NTR_WR, GRP_SEL, iscb_pkg::GRP_QUAL)) begin
                qual_ntr_ff <= WR_DATA;
            end
            if (sel_wr(NTR_WR, GRP_SEL, iscb_pkg::GRP_PROC)) begin
                proc_ntr_ff <= WR_DATA;
            end
            if (sel_wr(NTR_WR, GRP_SEL, iscb_pkg::GRP_FAULT)) begin
                fault_ntr_ff <= WR_DATA;
            end
        end
    end

    iscb_event_group #(.W(W)) u_qual_grp (
        .clk(REF_CLK),
        .rst(SYS_RST),
        .cond(qual_view),
        .ptr(qual_ptr_ff),
        .ntr(qual_ntr_ff),
        .enable(qual_en_ff),
        .evt_read(sel_wr(EVENT_RD, GRP_SEL, iscb_pkg::GRP_QUAL)),
        .evt_clear(CLS),
        .event_ff(qual_evt),
        .summary(qual_sum)
    );

    iscb_event_group #(.W(W)) u_proc_grp (
        .clk(REF_CLK),
        .rst(SYS_RST),
        .cond(proc_view),
        .ptr(proc_ptr_ff),
        .ntr(proc_ntr_ff),
        .enable(proc_en_ff),
        .evt_read(sel_wr(EVENT_RD, GRP_SEL, iscb_pkg::GRP_PROC)),
        .evt_clear(CLS),
        .event_ff(proc_evt),
        .summary(proc_sum)
    );

    iscb_event_group #(.W(W)) u_fault_grp (
        .clk(REF_CLK),
        .rst(SYS_RST),
        .cond(fault_view),
        .ptr(fault_ptr_ff),
        .ntr(fault_ntr_ff),
        .enable(fault_en_ff),
        .evt_read(sel_wr(EVENT_RD, GRP_SEL, iscb_pkg::GRP_FAULT)),
        .evt_clear(CLS),
        .event_ff(fault_evt),
        .summary(fault_sum)
    );

    iscb_opc_tracker u_opc (
        .clk(REF_CLK),
        .rst(SYS_RST),
        .pend_busy(PEND_BUSY),
        .opc_query(OPC_QUERY),
        .opc_cmd(OPC_CMD),
        .abort(DEV_CLEAR),
        .reply_push(opc_push),
        .esr_set(opc_set)
    );

    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            ese_ff <= iscb_pkg::ESE_RST;
        end else if (ESE_WR) begin
            ese_ff <= WR_DATA[7:0];
        end
    end

    // completion arriving with the clearing read is kept
    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            esr_ff <= '0;
        end else if (ESR_RD || CLS) begin
            esr_ff <= {7'h00, opc_set};
        end else if (opc_set) begin
            esr_ff[iscb_pkg::ESR_OPC_BIT] <= 1'b1;
        end
    end

    // status byte is purely combinational, so a poll has nothing to clear
    always_comb begin
        stb = '0;
        stb[iscb_pkg::STB_FAULT_BIT] = fault_sum;
        stb[iscb_pkg::STB_QUAL_BIT] = qual_sum;
        stb[iscb_pkg::STB_MAV_BIT] = OUTQ_NOT_EMPTY;
        stb[iscb_pkg::STB_ESB_BIT] = |(esr_ff & ese_ff);
        stb[iscb_pkg::STB_PROC_BIT] = proc_sum;
    end

    always_comb begin
        rd_mux = '0;
        if (STB_RD) begin
            rd_mux = {8'h00, stb};
        end else if (ESR_RD) begin
            rd_mux = {8'h00, esr_ff};
        end else if (COND_RD || EVENT_RD) begin
            unique case (GRP_SEL)
                iscb_pkg::GRP_QUAL: rd_mux = COND_RD ? qual_view : qual_evt;
                iscb_pkg::GRP_PROC: rd_mux = COND_RD ? proc_view : proc_evt;
                iscb_pkg::GRP_FAULT: rd_mux = COND_RD ? fault_view : fault_evt;
                default: rd_mux = '0;
            endcase
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            RD_DATA <= '0;
            RD_VALID <= 1'b0;
        end else begin
            RD_DATA <= rd_mux;
            RD_VALID <= STB_RD || ESR_RD || COND_RD || EVENT_RD;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            OUTQ_PUSH <= 1'b0;
            OUTQ_DATA <= '0;
        end else begin
            OUTQ_PUSH <= opc_push;
            OUTQ_DATA <= opc_push ? iscb_pkg::OPC_REPLY : OUTQ_DATA;
        end
    end

    assign QUAL_COND = qual_view;
    assign PROC_COND = proc_view;
    assign FAULT_COND = fault_view;
endmodule : iscb_status_core

// ==== verification/iscb_status_core_monitor.sv ====
/*
 checker for the status core: condition views, limit and calibration bits,
 completion reply. assumes one REF_CLK domain with SYS_RST as its reset.
*/
`timescale 1ns/10ps
module iscb_status_core_monitor (
    input wire logic REF_CLK,
    input wire logic SYS_RST,
    input wire logic MEAS_DONE,
    input wire logic MEAS_DATA_ERR,
    input wire logic MEAS_ACTIVE,
    input wire logic LOWER_LIMIT_EN,
    input wire logic LOWER_LIMIT_FAIL,
    input wire logic UPPER_LIMIT_EN,
    input wire logic UPPER_LIMIT_FAIL,
    input wire logic CAL_START,
    input wire logic CAL_END,
    input wire logic CAL_ERR,
    input wire logic TRIG_WAIT_ENTER,
    input wire logic NVM_READING,
    input wire logic HW_FAILED,
    input wire logic PEND_BUSY,
    input wire logic OPC_QUERY,
    input wire logic OUTQ_PUSH,
    input wire logic [7:0] OUTQ_DATA,
    input wire logic [15:0] QUAL_COND,
    input wire logic [15:0] PROC_COND,
    input wire logic [15:0] FAULT_COND
);
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (SYS_RST);
    AST_BIT15: assert property (!QUAL_COND[15] && !PROC_COND[15] && !FAULT_COND[15])
        else $error("bit 15 set in a condition group");
    AST_UNUSED: assert property ((QUAL_COND & 16'hfcf7) == 16'h0000
        && (PROC_COND & 16'he3ce) == 16'h0000 && (FAULT_COND & 16'hfff7) == 16'h0000)
        else $error("unused condition bit set");
    AST_MEAS: assert property (PROC_COND[4] == (MEAS_ACTIVE && !MEAS_DONE))
        else $error("measuring bit wrong");
    AST_NVM: assert property (PROC_COND[10] == NVM_READING)
        else $error("memory read bit wrong");
    AST_FAULT: assert property (FAULT_COND[3] == $past(HW_FAILED))
        else $error("fault bit wrong");
    AST_LIM: assert property (MEAS_DONE |=> PROC_COND[12:11] ==
        {$past(UPPER_LIMIT_EN) && $past(UPPER_LIMIT_FAIL),
        $past(LOWER_LIMIT_EN) && $past(LOWER_LIMIT_FAIL)})
        else $error("limit bits wrong after measurement");
    AST_QDATA: assert property (MEAS_DONE |=> QUAL_COND[3] == $past(MEAS_DATA_ERR))
        else $error("data quality bit wrong");
    AST_QCAL: assert property (CAL_END |=> QUAL_COND[8] == $past(CAL_ERR))
        else $error("calibration quality bit wrong");
    AST_CAL: assert property (CAL_START && !CAL_END |=> PROC_COND[0])
        else $error("calibrating bit not set");
    AST_TRIG: assert property ($rose(PROC_COND[5]) |-> $past(TRIG_WAIT_ENTER))
        else $error("trigger wait bit rose without cause");
    AST_OPC: assert property (OPC_QUERY && !PEND_BUSY |=>
        OUTQ_PUSH && OUTQ_DATA == 8'h01)
        else $error("completion reply missing");
    AST_NOPUSH: assert property (PEND_BUSY |=> !OUTQ_PUSH)
        else $error("reply pushed while busy");
    C_LIM: cover property (MEAS_DONE && LOWER_LIMIT_EN && LOWER_LIMIT_FAIL);
    C_WAIT: cover property (PEND_BUSY ##1 !PEND_BUSY ##1 OUTQ_PUSH);
    C_CAL: cover property (CAL_END && CAL_ERR);
endmodule : iscb_status_core_monitor

bind iscb_status_core iscb_status_core_monitor u_mon (.REF_CLK, .SYS_RST, .MEAS_DONE,
    .MEAS_DATA_ERR, .MEAS_ACTIVE, .LOWER_LIMIT_EN, .LOWER_LIMIT_FAIL, .UPPER_LIMIT_EN,
    .UPPER_LIMIT_FAIL, .CAL_START, .CAL_END, .CAL_ERR, .TRIG_WAIT_ENTER, .NVM_READING,
    .HW_FAILED, .PEND_BUSY, .OPC_QUERY, .OUTQ_PUSH, .OUTQ_DATA, .QUAL_COND, .PROC_COND,
    .FAULT_COND);

// ==== verification/iscb_host_model.sv ====
/*
 host software model: issues status commands as one-cycle strobes and takes
 read answers. assumes the core answers a read one edge after the strobe.
*/
`timescale 1ns/10ps
module iscb_host_model (
    input wire logic REF_CLK,
    input wire logic [15:0] RD_DATA,
    input wire logic RD_VALID,
    output logic [1:0] GRP_SEL,
    output logic [15:0] WR_DATA,
    output logic ENABLE_WR,
    output logic PTR_WR,
    output logic NTR_WR,
    output logic COND_RD,
    output logic EVENT_RD,
    output logic ESE_WR,
    output logic ESR_RD,
    output logic STB_RD,
    output logic CLS,
    output logic DEV_CLEAR,
    output logic OPC_QUERY,
    output logic OPC_CMD
);
    logic [11:0] stb;
    assign {ENABLE_WR, PTR_WR, NTR_WR, COND_RD, EVENT_RD, ESE_WR, ESR_RD, STB_RD, CLS,
        DEV_CLEAR, OPC_QUERY, OPC_CMD} = stb;
    initial begin
        stb = 12'h000;
        GRP_SEL = 2'h0;
        WR_DATA = 16'h0000;
    end
    // data is inverted once released so a stale word is never mistaken for a live one
    task automatic op(input int k, input logic [1:0] g, input logic [15:0] d);
        @(posedge REF_CLK);
        #1;
        stb = 12'h800 >> k;
        GRP_SEL = g;
        WR_DATA = d;
        @(posedge REF_CLK);
        #1;
        stb = 12'h000;
        WR_DATA = ~d;
    endtask : op
    task automatic rd(input int k, input logic [1:0] g, output logic [15:0] q, output bit ok);
        op(k, g, 16'h0000);
        ok = RD_VALID;
        q = RD_DATA;
    endtask : rd
    // clear, clear status, enable completion, then the completion query
    task automatic sync_start;
        op(9, 2'h0, 16'h0000);
        op(8, 2'h0, 16'h0000);
        op(5, 2'h0, 16'h0001);
        op(10, 2'h0, 16'h0000);
    endtask : sync_start
endmodule : iscb_host_model

// ==== verification/iscb_status_core_bench.sv ====
/*
 bench for the status core: engine events driven here, status commands
 through the host model. assumes the package and design files compiled first.
*/
`timescale 1ns/10ps
module iscb_status_core_bench;
    localparam int EN = 0, PTR = 1, NTR = 2, CRD = 3, ERD = 4, ESR = 6, STB = 7, OQ = 10, OC = 11;
    logic REF_CLK, SYS_RST, MEAS_DONE, MEAS_DATA_ERR, MEAS_ACTIVE, LOWER_LIMIT_EN;
    logic LOWER_LIMIT_FAIL, UPPER_LIMIT_EN, UPPER_LIMIT_FAIL, CAL_START, CAL_END, CAL_ERR;
    logic SELFTEST_DONE, SELFTEST_FAIL, TRIG_WAIT_ENTER, TRIG_IDLE_ENTER, NVM_READING;
    logic HW_FAILED, PEND_BUSY, OUTQ_NOT_EMPTY, RD_VALID, OUTQ_PUSH;
    logic ENABLE_WR, PTR_WR, NTR_WR, COND_RD, EVENT_RD, ESE_WR, ESR_RD, STB_RD, CLS, DEV_CLEAR;
    logic OPC_QUERY, OPC_CMD;
    logic [1:0] GRP_SEL;
    logic [7:0] OUTQ_DATA;
    logic [15:0] WR_DATA, RD_DATA, QUAL_COND, PROC_COND, FAULT_COND, q;
    bit ok;
    int bad_count, comparisons;
    iscb_status_core u_dut (.REF_CLK, .SYS_RST, .MEAS_DONE, .MEAS_DATA_ERR, .MEAS_ACTIVE,
        .LOWER_LIMIT_EN, .LOWER_LIMIT_FAIL, .UPPER_LIMIT_EN, .UPPER_LIMIT_FAIL, .CAL_START,
        .CAL_END, .CAL_ERR, .SELFTEST_DONE, .SELFTEST_FAIL, .TRIG_WAIT_ENTER, .TRIG_IDLE_ENTER,
        .NVM_READING, .HW_FAILED, .PEND_BUSY, .GRP_SEL, .WR_DATA, .ENABLE_WR, .PTR_WR, .NTR_WR,
        .COND_RD, .EVENT_RD, .ESE_WR, .ESR_RD, .STB_RD, .CLS, .DEV_CLEAR, .OPC_QUERY, .OPC_CMD,
        .OUTQ_NOT_EMPTY, .RD_DATA, .RD_VALID, .OUTQ_PUSH, .OUTQ_DATA, .QUAL_COND, .PROC_COND,
        .FAULT_COND);
    iscb_host_model u_host (.REF_CLK, .RD_DATA, .RD_VALID, .GRP_SEL, .WR_DATA, .ENABLE_WR,
        .PTR_WR, .NTR_WR, .COND_RD, .EVENT_RD, .ESE_WR, .ESR_RD, .STB_RD, .CLS, .DEV_CLEAR,
        .OPC_QUERY, .OPC_CMD);
    initial begin
        REF_CLK = 1'b0;
        forever #10 REF_CLK = ~REF_CLK;
    end
    task automatic stop_test;
        $display("counts: %0d comparisons, %0d mismatches", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : stop_test
    task automatic chk(input string n, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %s exp %h seen %h", n, exp, seen);
        end
    endtask : chk
    task automatic tick;
        @(posedge REF_CLK);
        #1;
    endtask : tick
    task automatic pulse(ref logic s);
        tick();
        s = 1'b1;
        tick();
        s = 1'b0;
    endtask : pulse
    task automatic rdc(input int k, input logic [1:0] g, input string n, input logic [15:0] e);
        u_host.rd(k, g, q, ok);
        chk(n, {15'h0000, ok}, 16'h0001);
        chk(n, q, e);
    endtask : rdc
    // a reply that never comes ends the run rather than hanging it
    task automatic wait_push;
        int i;
        for (i = 0; i < 5 && OUTQ_PUSH !== 1'b1; i++) begin
            tick();
        end
        if (i == 5) begin
            bad_count++;
            $display("BAD reply push exp 1 seen 0");
            stop_test();
        end
    endtask : wait_push
    initial begin
        {MEAS_DONE, MEAS_DATA_ERR, MEAS_ACTIVE, LOWER_LIMIT_EN, LOWER_LIMIT_FAIL, UPPER_LIMIT_EN,
            UPPER_LIMIT_FAIL, CAL_START, CAL_END, CAL_ERR, SELFTEST_DONE, SELFTEST_FAIL,
            TRIG_WAIT_ENTER, TRIG_IDLE_ENTER, NVM_READING, HW_FAILED, PEND_BUSY,
            OUTQ_NOT_EMPTY} = '0;
        SYS_RST = 1'b1;
        bad_count = 0;
        comparisons = 0;
        repeat (20) @(posedge REF_CLK);
        #1;
        SYS_RST = 1'b0;
        chk("proc rst", PROC_COND, 16'h0000);
        chk("qual rst", QUAL_COND | FAULT_COND, 16'h0000);
        rdc(CRD, 2'h3, "grp3", 16'h0000);
        $display("test reset ends");
        MEAS_ACTIVE = 1'b1;
        {MEAS_DATA_ERR, LOWER_LIMIT_EN, LOWER_LIMIT_FAIL, UPPER_LIMIT_EN,
            UPPER_LIMIT_FAIL} = 5'h1d;
        tick();
        chk("measuring", PROC_COND, 16'h0010);
        pulse(MEAS_DONE);
        MEAS_ACTIVE = 1'b0;
        tick();
        chk("lower fail", PROC_COND, 16'h0800);
        chk("data err", QUAL_COND, 16'h0008);
        {MEAS_DATA_ERR, LOWER_LIMIT_EN, LOWER_LIMIT_FAIL, UPPER_LIMIT_EN,
            UPPER_LIMIT_FAIL} = 5'h0b;
        pulse(MEAS_DONE);
        chk("upper fail", PROC_COND, 16'h1000);
        chk("data clean", QUAL_COND, 16'h0000);
        $display("test measurement ends");
        pulse(CAL_START);
        chk("cal run", PROC_COND, 16'h1001);
        CAL_ERR = 1'b1;
        pulse(CAL_END);
        chk("cal end", PROC_COND, 16'h1000);
        chk("cal err", QUAL_COND, 16'h0100);
        CAL_ERR = 1'b0;
        pulse(CAL_START);
        pulse(CAL_END);
        chk("cal ok", QUAL_COND, 16'h0000);
        SELFTEST_FAIL = 1'b1;
        pulse(SELFTEST_DONE);
        chk("st fail", QUAL_COND, 16'h0200);
        SELFTEST_FAIL = 1'b0;
        pulse(SELFTEST_DONE);
        chk("st pass", QUAL_COND, 16'h0000);
        $display("test calibration ends");
        pulse(TRIG_WAIT_ENTER);
        NVM_READING = 1'b1;
        tick();
        chk("trig nvm", PROC_COND, 16'h1420);
        pulse(TRIG_IDLE_ENTER);
        NVM_READING = 1'b0;
        tick();
        chk("idle", PROC_COND, 16'h1000);
        rdc(ERD, 2'h1, "proc evt", 16'h1c31);
        rdc(ERD, 2'h1, "proc evt2", 16'h0000);
        rdc(ERD, 2'h0, "qual evt", 16'h0308);
        u_host.op(PTR, 2'h2, 16'h0000);
        u_host.op(NTR, 2'h2, 16'h0008);
        HW_FAILED = 1'b1;
        tick();
        chk("hw fail", FAULT_COND, 16'h0008);
        rdc(ERD, 2'h2, "fault rise", 16'h0000);
        HW_FAILED = 1'b0;
        tick();
        chk("hw ok", FAULT_COND, 16'h0000);
        rdc(ERD, 2'h2, "fault fall", 16'h0008);
        $display("test events ends");
        SELFTEST_FAIL = 1'b1;
        pulse(SELFTEST_DONE);
        rdc(STB, 2'h0, "stb masked", 16'h0000);
        u_host.op(EN, 2'h0, 16'h0200);
        rdc(STB, 2'h0, "stb qual", 16'h0008);
        OUTQ_NOT_EMPTY = 1'b1;
        rdc(STB, 2'h0, "stb again", 16'h0018);
        OUTQ_NOT_EMPTY = 1'b0;
        $display("test summary ends");
        u_host.sync_start();
        chk("reply", {7'h00, OUTQ_PUSH, OUTQ_DATA}, 16'h0101);
        PEND_BUSY = 1'b1;
        u_host.op(OQ, 2'h0, 16'h0000);
        chk("early reply", {15'h0000, OUTQ_PUSH}, 16'h0000);
        tick();
        PEND_BUSY = 1'b0;
        wait_push();
        chk("late reply", {7'h00, OUTQ_PUSH, OUTQ_DATA}, 16'h0101);
        PEND_BUSY = 1'b1;
        u_host.op(OC, 2'h0, 16'h0000);
        rdc(STB, 2'h0, "stb busy", 16'h0000);
        PEND_BUSY = 1'b0;
        tick();
        tick();
        rdc(STB, 2'h0, "stb done", 16'h0020);
        rdc(ESR, 2'h0, "esr", 16'h0001);
        rdc(ESR, 2'h0, "esr read", 16'h0000);
        // a device clear cancels a query still waiting on pending commands
        PEND_BUSY = 1'b1;
        u_host.op(OQ, 2'h0, 16'h0000);
        u_host.op(9, 2'h0, 16'h0000);
        PEND_BUSY = 1'b0;
        tick();
        chk("aborted reply", {15'h0000, OUTQ_PUSH}, 16'h0000);
        $display("test completion ends");
        stop_test();
    end
endmodule : iscb_status_core_bench
